// ### src/vc_port_arb_capability_regs.sv
// port channel control, status and channel 0 capability registers
`timescale 1ns/1ps
module vc_port_arb_capability_regs (
  input  wire logic                  clk_sys,
  input  wire logic                  rst_b,
  input  wire logic                  upstream_strap,
  input  vc_arb_pkg::bus_req_t       req,
  output logic      [31:0]           rd_data,
  output logic      [2:0]            chan_arb_select,
  output logic                       is_upstream
);
  import vc_arb_pkg::*;

  typedef enum logic [1:0] {
    ST_STRAP = 2'b01,
    ST_RUN   = 2'b10
  } strap_state_t;

  strap_state_t   state_ff;
  strap_state_t   nxt_state;
  logic           upstream_ff;
  logic [2:0]     sel_ff;
  logic [2:0]     nxt_sel;
  logic           sel_wr;
  port_chan_ctl_t ctl_word;
  port_chan_sts_t sts_word;
  chan0_cap_t     cap_word;

  // role strap is caught once, on the first edge after reset release,
  // since an async reset may only load constants
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_STRAP: nxt_state = ST_RUN;
      ST_RUN:   nxt_state = ST_RUN;
      default:  nxt_state = ST_STRAP;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= ST_STRAP;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      upstream_ff <= 1'b0;
    end else if (state_ff == ST_STRAP) begin
      upstream_ff <= upstream_strap;
    end
  end

  // only the select field of the control register holds state
  assign sel_wr = req.wr && (req.addr == PORT_CHAN_CTL_OFS);

  always_comb begin
    nxt_sel = sel_ff;
    if (sel_wr) begin
      nxt_sel = req.wdata[SEL_MSB:SEL_LSB];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sel_ff <= SEL_RST;
    end else begin
      sel_ff <= nxt_sel;
    end
  end

  // load bit and reserved bits are not stored; writes to them vanish
  always_comb begin
    ctl_word      = '0;
    ctl_word.load = 1'b0;
    ctl_word.sel  = sel_ff;
    ctl_word.rsvd = '0;
  end

  // single channel: table status has nothing to report
  always_comb begin
    sts_word         = '0;
    sts_word.tbl_sts = 1'b0;
    sts_word.rsvd    = '0;
  end

  chan0_cap_encode u_cap (
    .upstream (upstream_ff),
    .cap      (cap_word)
  );

  reg_read_port u_read (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .rd       (req.rd),
    .addr     (req.addr),
    .ctl_word (ctl_word),
    .sts_word (sts_word),
    .cap_word (cap_word),
    .rd_data  (rd_data)
  );

  assign chan_arb_select = sel_ff;
  assign is_upstream     = upstream_ff;

  // checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  sequence ctl_rd_s;
    req.rd && (req.addr == PORT_CHAN_CTL_OFS);
  endsequence

  sequence sts_rd_s;
    req.rd && (req.addr == PORT_CHAN_STS_OFS);
  endsequence

  sequence cap_rd_s;
    req.rd && (req.addr == CHAN0_CAP_OFS) && (state_ff == ST_RUN);
  endsequence

  sequence ctl_wr_s;
    req.wr && (req.addr == PORT_CHAN_CTL_OFS);
  endsequence

  sequence unmapped_rd_s;
    req.rd && (req.addr != PORT_CHAN_CTL_OFS)
      && (req.addr != PORT_CHAN_STS_OFS)
      && (req.addr != CHAN0_CAP_OFS)
      && (req.addr != CHAN_ARB_CAP_OFS);
  endsequence

  load_bit_zero_a: assert property (
    ctl_rd_s |=> (rd_data[LOAD_BIT] == 1'b0))
    else $error("load table bit read back as one");

  load_wr_inert_a: assert property (
    ctl_wr_s ##1 ctl_rd_s |=> (rd_data[LOAD_BIT] == 1'b0))
    else $error("write to load table bit was stored");

  sel_readback_a: assert property (
    ctl_wr_s ##1 (ctl_rd_s and !req.wr)
      |=> (rd_data[SEL_MSB:SEL_LSB]
           == $past(req.wdata[SEL_MSB:SEL_LSB], 2)))
    else $error("select field did not read back written value");

  sel_output_a: assert property (
    ctl_wr_s |=> (chan_arb_select == $past(req.wdata[SEL_MSB:SEL_LSB])))
    else $error("select output did not follow write");

  sel_reset_a: assert property (
    $rose(rst_b) |-> (sel_ff == SEL_RST))
    else $error("select field not zero after reset");

  tbl_status_a: assert property (
    sts_rd_s |=> (rd_data[TBL_STS_BIT] == 1'b0))
    else $error("table status bit read as one");

  port_cap_role_a: assert property (
    cap_rd_s |=> (rd_data[ARB_CAP_MSB:0]
                  == (upstream_ff ? ARB_CAP_UP : ARB_CAP_DN)))
    else $error("port arbitration capability wrong for role");

  scheme_bits_a: assert property (
    cap_rd_s |=> (rd_data[ARB_CAP_MSB:SCHEME_WRR256 + 1] == 2'b00)
                 && rd_data[SCHEME_FIXED_RR])
    else $error("capability uses bits outside the scheme set");

  aps_zero_a: assert property (
    cap_rd_s |=> (rd_data[APS_BIT] == 1'b0))
    else $error("packet switching bit read as one");

  snoop_zero_a: assert property (
    cap_rd_s |=> (rd_data[SNOOP_BIT] == 1'b0))
    else $error("reject snoop bit read as one");

  max_slots_a: assert property (
    cap_rd_s |=> (rd_data[MAX_TIME_SLOTS_MSB:MAX_TIME_SLOTS_LSB] == MAX_SLOTS))
    else $error("maximum time slots not zero");

  tbl_offset_a: assert property (
    cap_rd_s |=> (rd_data[TBL_OFS_MSB:TBL_OFS_LSB]
                  == (upstream_ff ? TBL_OFS_UP : TBL_OFS_DN)))
    else $error("table offset wrong for role");

  ctl_rsvd_a: assert property (
    ctl_rd_s |=> (rd_data[DATA_W-1:SEL_MSB+1] == 28'h000_0000))
    else $error("control reserved bits not zero");

  sts_rsvd_a: assert property (
    sts_rd_s |=> (rd_data[DATA_W-1:1] == 31'h0000_0000))
    else $error("status reserved bits not zero");

  chan_cap_zero_a: assert property (
    req.rd && (req.addr == CHAN_ARB_CAP_OFS)
      |=> (rd_data == ZERO_WORD))
    else $error("channel arbitration capability not zero");

  ro_write_a: assert property (
    req.wr && (req.addr != PORT_CHAN_CTL_OFS) |=> $stable(sel_ff))
    else $error("write elsewhere changed select field");

  unmapped_zero_a: assert property (
    unmapped_rd_s |=> (rd_data == ZERO_WORD))
    else $error("unmapped read returned data");

  idle_zero_a: assert property (
    !req.rd |=> (rd_data == ZERO_WORD))
    else $error("read data stood beyond its cycle");

  strap_once_a: assert property (
    (state_ff == ST_RUN) |=> $stable(upstream_ff))
    else $error("role changed after it was caught");

  // the release edge itself still runs the reset branch, so the strap
  // is taken one edge later; sampled rst_b tells the two apart
  sequence strap_edge_s;
    (state_ff == ST_STRAP) && rst_b;
  endsequence

  strap_catch_a: assert property (
    strap_edge_s |=> (upstream_ff == $past(upstream_strap)))
    else $error("role not taken from the strap");

  run_after_strap_a: assert property (
    strap_edge_s |=> (state_ff == ST_RUN))
    else $error("strap state did not move on");

  run_stays_a: assert property (
    (state_ff == ST_RUN) |=> (state_ff == ST_RUN))
    else $error("left the run state without reset");

  state_onehot_a: assert property (
    $onehot(state_ff))
    else $error("strap state code not one-hot");

  strap_first_a: assert property (
    $rose(rst_b) |-> (state_ff == ST_STRAP))
    else $error("strap state not entered after reset");

  role_reset_a: assert property (
    $rose(rst_b) |-> !is_upstream)
    else $error("role not cleared by reset");

  sel_reset_out_a: assert property (
    $rose(rst_b) |-> (chan_arb_select == SEL_RST))
    else $error("select output not zero after reset");

  sel_hold_a: assert property (
    !(req.wr && (req.addr == PORT_CHAN_CTL_OFS)) |=> $stable(sel_ff))
    else $error("select field changed without a write");

  // read data groups
  ctl_readback_a: assert property (
    ctl_rd_s |=> (rd_data[SEL_MSB:SEL_LSB] == $past(sel_ff)))
    else $error("control read did not show stored select");

  ctl_half_zero_a: assert property (
    ctl_rd_s |=> (rd_data[HALF_W-1:SEL_MSB+1] == 12'h000))
    else $error("control reserved field not zero");

  sts_word_zero_a: assert property (
    sts_rd_s |=> (rd_data == ZERO_WORD))
    else $error("status word not zero");

  half_lanes_a: assert property (
    (ctl_rd_s or sts_rd_s)
      |=> (rd_data[DATA_W-1:HALF_W] == 16'h0000))
    else $error("unused upper lanes of a half register not zero");

  cap_up_word_a: assert property (
    (cap_rd_s and upstream_ff)
      |=> (rd_data == {TBL_OFS_UP, 16'h0000, ARB_CAP_UP}))
    else $error("upstream capability word wrong");

  cap_dn_word_a: assert property (
    (cap_rd_s and !upstream_ff)
      |=> (rd_data == {TBL_OFS_DN, 16'h0000, ARB_CAP_DN}))
    else $error("downstream capability word wrong");

  wrr32_role_a: assert property (
    cap_rd_s |=> (rd_data[SCHEME_WRR32] == upstream_ff))
    else $error("32-phase scheme bit wrong for role");

  unsup_schemes_a: assert property (
    cap_rd_s |=> (rd_data[SCHEME_TWRR128:SCHEME_WRR64] == 3'h0)
                 && !rd_data[SCHEME_WRR256])
    else $error("unsupported scheme bit advertised");

  cap_rsvd_zero_a: assert property (
    cap_rd_s |=> (rd_data[APS_BIT-1:ARB_CAP_MSB+1] == 6'h00)
                 && !rd_data[MAX_TIME_SLOTS_MSB+1])
    else $error("capability reserved bits not zero");

  cap_stable_a: assert property (
    (state_ff == ST_RUN) |=> $stable(cap_word))
    else $error("capability word moved while running");

  wr_no_data_a: assert property (
    req.wr |=> (rd_data == ZERO_WORD))
    else $error("write produced read data");

endmodule

// ### src/vc_arb_pkg.sv
// constants, field layouts and carriers for the port channel registers
// Operation
// - load-table control bit 0 always reads zero; writing it does nothing.
// - select field bits 3:1 is writable, resets to zero, drives chan_arb_select.
// - table status bit 0 of the status register is read-only zero.
// - port arbitration capability reads 0x3 upstream and 0x1 downstream.
// - capability field uses one bit per arbitration scheme, bits 0 to 5.
// - advanced packet switching bit 14 is read-only zero.
// - reject-snoop bit 15 is read-only zero on every switch port.
// - maximum time slots field 22:16 is read-only zero.
// - table offset 31:24 in 16-byte units: 0x2 upstream, 0x0 downstream.
// - control register decodes at 0x20c; bits 15:4 read zero.
// - status register decodes at 0x20e; bits 15:1 read zero.
// - channel arbitration capability field reads zero.
package vc_arb_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;

  // register offsets
  localparam logic [11:0] CHAN_ARB_CAP_OFS  = 12'h208;
  localparam logic [11:0] PORT_CHAN_CTL_OFS = 12'h20c;
  localparam logic [11:0] PORT_CHAN_STS_OFS = 12'h20e;
  localparam logic [11:0] CHAN0_CAP_OFS     = 12'h210;

  // field positions
  localparam int unsigned LOAD_BIT      = 0;
  localparam int unsigned SEL_LSB       = 1;
  localparam int unsigned SEL_MSB       = 3;
  localparam int unsigned TBL_STS_BIT   = 0;
  localparam int unsigned ARB_CAP_MSB   = 7;
  localparam int unsigned APS_BIT       = 14;
  localparam int unsigned SNOOP_BIT     = 15;
  localparam int unsigned MAX_TIME_SLOTS_LSB     = 16;
  localparam int unsigned MAX_TIME_SLOTS_MSB     = 22;
  localparam int unsigned TBL_OFS_LSB   = 24;
  localparam int unsigned TBL_OFS_MSB   = 31;
  localparam int unsigned HALF_W        = 16;

  // one bit per port arbitration scheme
  localparam int unsigned SCHEME_FIXED_RR = 0;
  localparam int unsigned SCHEME_WRR32    = 1;
  localparam int unsigned SCHEME_WRR64    = 2;
  localparam int unsigned SCHEME_WRR128   = 3;
  localparam int unsigned SCHEME_TWRR128  = 4;
  localparam int unsigned SCHEME_WRR256   = 5;

  // reset and fixed values
  localparam logic [2:0] SEL_RST          = 3'h0;
  localparam logic [7:0] ARB_CAP_UP       = 8'h03;
  localparam logic [7:0] ARB_CAP_DN       = 8'h01;
  localparam logic [7:0] TBL_OFS_UP       = 8'h02;
  localparam logic [7:0] TBL_OFS_DN       = 8'h00;
  localparam logic [6:0] MAX_SLOTS        = 7'h00;
  localparam logic [7:0] CHAN_ARB_CAP     = 8'h00;
  localparam logic [31:0] ZERO_WORD       = 32'h0000_0000;

  typedef struct packed {
    logic              rd;
    logic              wr;
    logic [11:0]       addr;
    logic [31:0]       wdata;
  } bus_req_t;

  typedef struct packed {
    logic [11:0]       rsvd;
    logic [2:0]        sel;
    logic              load;
  } port_chan_ctl_t;

  typedef struct packed {
    logic [14:0]       rsvd;
    logic              tbl_sts;
  } port_chan_sts_t;

  typedef struct packed {
    logic [7:0]        tbl_ofs;
    logic              rsvd23;
    logic [6:0]        max_slots;
    logic              snoop;
    logic              adv_packet_switching;
    logic [5:0]        rsvd;
    logic [7:0]        arb_cap;
  } chan0_cap_t;

endpackage

// ### src/chan0_cap_encode.sv
// builds the channel 0 capability word for the port's role
`timescale 1ns/1ps
module chan0_cap_encode (
  input  wire logic                  upstream,
  output vc_arb_pkg::chan0_cap_t     cap
);
  import vc_arb_pkg::*;

  logic [7:0] arb_bits;

  // each scheme bit chosen independently per role
  for (genvar i = 0; i <= ARB_CAP_MSB; i++) begin : g_scheme
    assign arb_bits[i] = upstream ? ARB_CAP_UP[i] : ARB_CAP_DN[i];
  end

  always_comb begin
    cap           = '0;
    cap.arb_cap   = arb_bits;
    cap.adv_packet_switching       = 1'b0;
    cap.snoop     = 1'b0;
    cap.max_slots = MAX_SLOTS;
    cap.tbl_ofs   = upstream ? TBL_OFS_UP : TBL_OFS_DN;
  end

endmodule

// ### src/reg_read_port.sv
// decodes a read and holds its data for exactly the following cycle
`timescale 1ns/1ps
module reg_read_port (
  input  wire logic                  clk_sys,
  input  wire logic                  rst_b,
  input  wire logic                  rd,
  input  wire logic [11:0]           addr,
  input  wire logic [15:0]           ctl_word,
  input  wire logic [15:0]           sts_word,
  input  wire logic [31:0]           cap_word,
  output logic      [31:0]           rd_data
);
  import vc_arb_pkg::*;

  logic [31:0] nxt_rd_data;
  logic [31:0] rd_data_ff;

  always_comb begin
    nxt_rd_data = ZERO_WORD;
    if (rd) begin
      unique case (addr)
        CHAN_ARB_CAP_OFS:  nxt_rd_data = {24'h00_0000, CHAN_ARB_CAP};
        PORT_CHAN_CTL_OFS: nxt_rd_data = {16'h0000, ctl_word};
        PORT_CHAN_STS_OFS: nxt_rd_data = {16'h0000, sts_word};
        CHAN0_CAP_OFS:     nxt_rd_data = cap_word;
        default:           nxt_rd_data = ZERO_WORD;
      endcase
    end
  end

  // data drops back to zero after one cycle so stale words never linger
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rd_data_ff <= ZERO_WORD;
    end else begin
      rd_data_ff <= nxt_rd_data;
    end
  end

  assign rd_data = rd_data_ff;

endmodule

// ### src/dummy_unused_never.sv
`timescale 1ns/1ps

// ### verification/tb_vc_port_arb_capability_regs.sv
// self-checking bench for the port channel capability registers
`timescale 1ns/1ps
module tb_vc_port_arb_capability_regs;
  import vc_arb_pkg::*;

  logic                  clk_sys;
  logic                  rst_b;
  logic                  upstream_strap;
  bus_req_t              req;
  logic [31:0]           rd_data;
  logic [2:0]            chan_arb_select;
  logic                  is_upstream;
  int                    failures;
  int                    num_checks;
  int                    cycles;

  vc_port_arb_capability_regs dut (
    .clk_sys         (clk_sys),
    .rst_b           (rst_b),
    .upstream_strap  (upstream_strap),
    .req             (req),
    .rd_data         (rd_data),
    .chan_arb_select (chan_arb_select),
    .is_upstream     (is_upstream)
  );

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic stop_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // a hang is cut short well after the sequence should have ended
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      failures = failures + 1;
      stop_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic do_reset(input logic role);
    upstream_strap <= role;
    rst_b <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    // role is caught at the first edge, first request at the second
    @(posedge clk_sys);
  endtask

  task automatic bus_wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge clk_sys);
    req <= '0;
  endtask

  task automatic bus_rd(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 32'h0000_0000};
    @(posedge clk_sys);
    req <= '0;
    @(negedge clk_sys);
    chk(rd_data, exp);
  endtask

  task automatic t_reset_values(input logic role);
    @(negedge clk_sys);
    chk({29'h0, chan_arb_select}, 32'h0000_0000);
    chk({31'h0, is_upstream}, {31'h0, role});
    bus_rd(12'h20c, 32'h0000_0000);
    bus_rd(12'h20e, 32'h0000_0000);
  endtask

  task automatic t_select_all();
    logic [31:0] wd;
    for (int v = 0; v < 8; v++) begin
      // load bit and reserved bits set on every write
      wd = {28'hfff_ffff, v[2:0], 1'b1};
      bus_wr(12'h20c, wd);
      @(negedge clk_sys);
      chk({29'h0, chan_arb_select}, {29'h0, v[2:0]});
      bus_rd(12'h20c, {28'h0, v[2:0], 1'b0});
      chk(rd_data & 32'hffff_fff0, 32'h0000_0000);
    end
  endtask

  task automatic t_ro_writes(input logic [31:0] cap);
    bus_wr(12'h20c, 32'h0000_000a);
    bus_wr(12'h20e, 32'hffff_ffff);
    bus_wr(12'h210, 32'hffff_ffff);
    bus_wr(12'h208, 32'hffff_ffff);
    bus_wr(12'h300, 32'hffff_ffff);
    bus_rd(12'h20e, 32'h0000_0000);
    bus_rd(12'h210, cap);
    bus_rd(12'h208, 32'h0000_0000);
    bus_rd(12'h300, 32'h0000_0000);
    @(negedge clk_sys);
    chk({29'h0, chan_arb_select}, 32'h0000_0005);
  endtask

  task automatic t_cap_fields(input logic up, input logic [31:0] cap);
    chan0_cap_t c;
    bus_rd(12'h210, cap);
    c = rd_data;
    chk({24'h0, c.arb_cap}, up ? 32'h0000_0003 : 32'h0000_0001);
    chk({31'h0, c.adv_packet_switching}, 32'h0000_0000);
    chk({31'h0, c.snoop}, 32'h0000_0000);
    chk({25'h0, c.max_slots}, 32'h0000_0000);
    chk({24'h0, c.tbl_ofs}, up ? 32'h0000_0002 : 32'h0000_0000);
    chk({31'h0, is_upstream}, {31'h0, up});
  endtask

  task automatic t_back_to_back(input logic [31:0] cap);
    // write with load bit set, then two reads, no idle cycle between
    @(posedge clk_sys);
    req <= '{rd: 1'b0, wr: 1'b1, addr: 12'h20c, wdata: 32'h0000_0007};
    @(posedge clk_sys);
    req <= '{rd: 1'b1, wr: 1'b0, addr: 12'h20c, wdata: 32'h0};
    @(posedge clk_sys);
    req <= '{rd: 1'b1, wr: 1'b0, addr: 12'h210, wdata: 32'h0};
    @(negedge clk_sys);
    chk(rd_data, 32'h0000_0006);
    @(posedge clk_sys);
    req <= '0;
    @(negedge clk_sys);
    chk(rd_data, cap);
    @(negedge clk_sys);
    chk(rd_data, 32'h0000_0000);
  endtask

  initial begin
    rst_b = 1'b0;
    upstream_strap = 1'b0;
    req = '0;
    failures = 0;
    num_checks = 0;
    cycles = 0;
    do_reset(1'b0);
    t_reset_values(1'b0);
    t_select_all();
    t_ro_writes(32'h0000_0001);
    t_cap_fields(1'b0, 32'h0000_0001);
    t_back_to_back(32'h0000_0001);
    // second reset in mid-run with the upstream role
    @(posedge clk_sys);
    do_reset(1'b1);
    t_reset_values(1'b1);
    t_cap_fields(1'b1, 32'h0200_0003);
    t_ro_writes(32'h0200_0003);
    // role stays as caught after reset, a strap change is ignored
    @(posedge clk_sys);
    upstream_strap <= 1'b0;
    t_back_to_back(32'h0200_0003);
    chk({31'h0, is_upstream}, 32'h0000_0001);
    stop_test();
  end
endmodule
